// ==== rtl/jisp_pkg.sv ====
/*
  Shared constants and types of the test-port and programming control block.
  Assumes an 8-bit host register window and a serial test controller on tck.
*/
package jisp_pkg;
  // ==========================================================
  // Register offsets and fields
  localparam logic [7:0] OFS_RUN_EN  = 8'hc7;
  localparam logic [7:0] OFS_PMR_A   = 8'hb0;
  localparam logic [7:0] OFS_PMR_C   = 8'hb4;
  localparam logic [7:0] OFS_MEMMAP  = 8'he0;
  localparam logic [7:0] REG_ZERO    = 8'h00;
  localparam logic [7:0] MM_INIT_DEF = 8'h00;
  localparam int RUN_EN_BIT    = 0;
  localparam int MM_SRCOD_BIT  = 0;
  localparam int MM_PERIPH_BIT = 7;
  // ==========================================================
  // Widths
  localparam int IR_W  = 8;
  localparam int DR_W  = 28;
  localparam int NSECT = 12;
  localparam int MC_W  = 16;
  localparam int PLD_W = 8;
  localparam int AD_W  = 16;
  // ==========================================================
  // Instruction codes
  localparam logic [IR_W-1:0] IR_BYPASS    = 8'hff;
  localparam logic [IR_W-1:0] IR_CAPTURE   = 8'h01;
  localparam logic [IR_W-1:0] IR_ENABLE    = 8'h0c;
  localparam logic [IR_W-1:0] IR_ENABLE_OD = 8'h0d;
  localparam logic [IR_W-1:0] IR_DISABLE   = 8'h0f;
  localparam logic [IR_W-1:0] IR_PROGRAM   = 8'h20;
  localparam logic [IR_W-1:0] IR_ERASE     = 8'h21;
  localparam logic [IR_W-1:0] IR_CHIP      = 8'h22;
  localparam logic [IR_W-1:0] IR_READ      = 8'h23;
  localparam logic [IR_W-1:0] IR_CLEAR     = 8'h24;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_PROGRAM = 3'h1, OP_ERASE = 3'h2,
    OP_CHIP = 3'h3, OP_READ = 3'h4, OP_CLEAR = 3'h5
  } jisp_op_t;
  typedef struct packed {
    jisp_op_t        op;
    logic [3:0]      sector;
    logic [AD_W-1:0] addr;
    logic [7:0]      data;
  } jisp_cmd_t;
  typedef struct packed {
    logic      valid;
    jisp_cmd_t cmd;
  } jisp_freq_t;
  typedef enum logic [3:0] {
    TS_EX2DR = 4'h0, TS_EX1DR = 4'h1, TS_SHDR = 4'h2, TS_PADR = 4'h3,
    TS_SELIR = 4'h4, TS_UPDR = 4'h5, TS_CAPDR = 4'h6, TS_SELDR = 4'h7,
    TS_EX2IR = 4'h8, TS_EX1IR = 4'h9, TS_SHIR = 4'ha, TS_PAIR = 4'hb,
    TS_RTI = 4'hc, TS_UPIR = 4'hd, TS_CAPIR = 4'he, TS_TLR = 4'hf
  } jisp_tap_t;
  typedef enum logic [0:0] {FL_READ = 1'b0, FL_BUSY = 1'b1} jisp_fl_t;
endpackage : jisp_pkg

// ==== rtl/jisp_tap.sv ====
/*
  Test-access state machine with instruction register, on tck.
  Assumes hold is already synchronous to tck.
*/
`timescale 1ns/1ps
module jisp_tap
  import jisp_pkg::*;
(
  // Clock and resets
  input  wire logic            tck,
  input  wire logic            por,
  input  wire logic            hold,
  // Serial pins
  input  wire logic            tms,
  input  wire logic            tdi,
  // State and instruction
  output jisp_tap_t            state,
  output logic [IR_W-1:0]      ir_sh,
  output logic [IR_W-1:0]      ir_q
);
  // ==========================================================
  // Next state
  function automatic jisp_tap_t f_next(jisp_tap_t s, logic m);
    case (s)
      TS_TLR:   f_next = m ? TS_TLR   : TS_RTI;
      TS_RTI:   f_next = m ? TS_SELDR : TS_RTI;
      TS_SELDR: f_next = m ? TS_SELIR : TS_CAPDR;
      TS_CAPDR: f_next = m ? TS_EX1DR : TS_SHDR;
      TS_SHDR:  f_next = m ? TS_EX1DR : TS_SHDR;
      TS_EX1DR: f_next = m ? TS_UPDR  : TS_PADR;
      TS_PADR:  f_next = m ? TS_EX2DR : TS_PADR;
      TS_EX2DR: f_next = m ? TS_UPDR  : TS_SHDR;
      TS_UPDR:  f_next = m ? TS_SELDR : TS_RTI;
      TS_SELIR: f_next = m ? TS_TLR   : TS_CAPIR;
      TS_CAPIR: f_next = m ? TS_EX1IR : TS_SHIR;
      TS_SHIR:  f_next = m ? TS_EX1IR : TS_SHIR;
      TS_EX1IR: f_next = m ? TS_UPIR  : TS_PAIR;
      TS_PAIR:  f_next = m ? TS_EX2IR : TS_PAIR;
      TS_EX2IR: f_next = m ? TS_UPIR  : TS_SHIR;
      TS_UPIR:  f_next = m ? TS_SELDR : TS_RTI;
      default:  f_next = TS_TLR;
    endcase
  endfunction : f_next

  // ==========================================================
  // State register
  always_ff @(posedge tck or posedge por) begin
    if (por) begin
      state <= TS_TLR;
    end else if (hold) begin
      state <= TS_TLR;
    end else begin
      state <= f_next(state, tms);
    end
  end

  // ==========================================================
  // Instruction shift and update
  always_ff @(posedge tck or posedge por) begin
    if (por) begin
      ir_sh <= IR_CAPTURE;
      ir_q  <= IR_BYPASS;
    end else if (hold || state == TS_TLR) begin
      ir_sh <= IR_CAPTURE;
      ir_q  <= IR_BYPASS;
    end else begin
      if (state == TS_CAPIR) begin
        ir_sh <= IR_CAPTURE;
      end else if (state == TS_SHIR) begin
        ir_sh <= {tdi, ir_sh[IR_W-1:1]};
      end
      if (state == TS_UPIR) begin
        ir_q <= ir_sh;
      end
    end
  end
endmodule : jisp_tap

// ==== rtl/jisp_ctrl.sv ====
/*
  Test-port pin ownership, programming command path, reset status handling.
  Assumes flash array, PLD array and host bus run on mclk; tck from cable.
*/
// Overview of operation
// - Reset aborts any flash program or erase and returns to read mode
// - PLD outputs valid after configuration load at power-on; valid in warm reset
// - Power-down: PLD outputs follow inputs, addresses blocked from array
// - Macrocell flops cleared by power-on; otherwise follow reset/preset terms
// - Memory map register loads initial value; two bits forced zero on reset
// - Test pins enabled when any of three enable sources is true
// - Without enable the four test pins return to general I/O
// - Enabled pins are inputs; data out drives only after enable command
// - Nonvolatile bit dedicates pins to test port permanently
// - Host enables pins via bit at C7h; reset or host write clears it
// - Dedicated product term is the third enable source
// - Reset halts test port unless pins are dedicated by nonvolatile bit or device is blank
// - Only in-system-configuration instructions, no boundary scan
// - Enable command activates status and error outputs, optionally open-drain
// - Error goes low on failure until clear or reset after disable
// - Status high in read mode, low while flash busy or secondary written
// - Blank device enables the four test pins by default
// - Secured device refuses reads; only full chip erase and clear accepted
// - Secured device blocks other commands; chip erase clears security
// - Each sector protect bit blocks erasure of that sector
// - Power-management registers cleared at power-up only
// - Run enable bit 0 enables port; bits 1 to 7 unused
`timescale 1ns/1ps
module jisp_ctrl
  import jisp_pkg::*;
#(
  parameter logic [7:0] MM_INIT = MM_INIT_DEF
) (
  // Clocks and resets
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              por,
  input  wire logic              tck,
  // Test pins
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe_n,
  output logic                   isc_status_out,
  output logic                   isc_status_oe_n,
  output logic                   isc_error_out,
  output logic                   isc_error_oe_n,
  output logic                   pins_gpio_mode,
  // Configuration
  input  wire logic              nvm_dedicate,
  input  wire logic              nvm_blank,
  input  wire logic              nvm_security,
  input  wire logic [NSECT-1:0]  sector_protect,
  input  wire logic              cfg_loaded,
  input  wire logic              test_select_product_term,
  // Host registers
  input  wire logic              io_sel,
  input  wire logic [7:0]        io_addr,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  input  wire logic [7:0]        io_wdata,
  output logic [7:0]             io_rdata,
  // Flash array
  output jisp_freq_t             flash_req,
  output logic                   flash_abort,
  input  wire logic              flash_done,
  input  wire logic              flash_fail,
  input  wire logic [7:0]        flash_rdata,
  input  wire logic              flash_sec_wr,
  // PLD and macrocells
  input  wire logic              pd_mode,
  input  wire logic [AD_W-1:0]   pld_addr,
  output logic [AD_W-1:0]        pld_addr_arr,
  input  wire logic [PLD_W-1:0]  pld_eval,
  output logic [PLD_W-1:0]       pld_out,
  output logic                   pld_valid,
  input  wire logic [MC_W-1:0]   mc_d,
  input  wire logic [MC_W-1:0]   mc_re,
  input  wire logic [MC_W-1:0]   mc_pr,
  output logic [MC_W-1:0]        mc_q,
  // Mapping and power registers
  output logic [7:0]             memory_map_reg,
  output logic [7:0]             power_mgmt_reg_a,
  output logic [7:0]             power_mgmt_reg_c
);
  // ==========================================================
  // Declarations
  logic        any_rst;
  logic        jtag_on;
  logic        hold_r;
  logic        hold_s1, hold_s2;
  logic        ack_r, ack_s1, ack_s2;
  logic        req_r, req_s1, req_s2, req_s3;
  logic        en_s1, en_s2, od_s1, od_s2;
  logic        rst_s1, rst_s2;
  logic        isc_en_r, isc_od_r;
  logic        run_en_r;
  logic        err_r;
  logic        new_cmd, refuse;
  logic        byp_r;
  logic [7:0]  rd_r;
  logic [DR_W-1:0] dr_r;
  logic [IR_W-1:0] ir_sh, ir_q;
  jisp_cmd_t   cmd_r;
  jisp_tap_t   tap_st;
  jisp_fl_t    fl_r;
  jisp_op_t    ir_op;
  logic        wr_hit;

  function automatic jisp_op_t f_op(logic [IR_W-1:0] ir);
    case (ir)
      IR_PROGRAM: f_op = OP_PROGRAM;
      IR_ERASE:   f_op = OP_ERASE;
      IR_CHIP:    f_op = OP_CHIP;
      IR_READ:    f_op = OP_READ;
      IR_CLEAR:   f_op = OP_CLEAR;
      default:    f_op = OP_NONE;
    endcase
  endfunction : f_op

  assign any_rst = rst | por;
  assign ir_op   = f_op(ir_q);
  assign wr_hit  = io_sel & io_wr;
  assign jtag_on = nvm_dedicate | nvm_blank | run_en_r | test_select_product_term;
  assign new_cmd = req_s2 ^ req_s3;
  assign refuse  = (nvm_security && cmd_r.op != OP_CHIP && cmd_r.op != OP_CLEAR)
                 || (cmd_r.op == OP_ERASE && sector_protect[cmd_r.sector]);

  // ==========================================================
  // Host registers
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      run_en_r       <= 1'b0;
      memory_map_reg <= MM_INIT & ~((8'h01 << MM_SRCOD_BIT) | (8'h01 << MM_PERIPH_BIT));
    end else if (wr_hit) begin
      if (io_addr == OFS_RUN_EN) begin
        run_en_r <= io_wdata[RUN_EN_BIT];
      end
      if (io_addr == OFS_MEMMAP) begin
        memory_map_reg <= io_wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      power_mgmt_reg_a <= REG_ZERO;
      power_mgmt_reg_c <= REG_ZERO;
    end else if (wr_hit) begin
      if (io_addr == OFS_PMR_A) begin
        power_mgmt_reg_a <= io_wdata;
      end
      if (io_addr == OFS_PMR_C) begin
        power_mgmt_reg_c <= io_wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      io_rdata <= REG_ZERO;
    end else if (io_sel && io_rd) begin
      case (io_addr)
        OFS_RUN_EN: io_rdata <= {7'h00, run_en_r};
        OFS_PMR_A:  io_rdata <= power_mgmt_reg_a;
        OFS_PMR_C:  io_rdata <= power_mgmt_reg_c;
        OFS_MEMMAP: io_rdata <= memory_map_reg;
        default:    io_rdata <= REG_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Pin ownership and test-port hold
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      pins_gpio_mode <= 1'b1;
      hold_r         <= 1'b1;
      rst_s1         <= 1'b1;
      rst_s2         <= 1'b1;
    end else begin
      rst_s1         <= rst;
      rst_s2         <= rst_s1;
      pins_gpio_mode <= ~jtag_on;
      hold_r         <= ~(nvm_dedicate | nvm_blank) & (rst_s2 | ~(run_en_r | test_select_product_term));
    end
  end

  // ==========================================================
  // Crossings into mclk
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
      od_s1  <= 1'b0;
      od_s2  <= 1'b0;
    end else begin
      req_s1 <= req_r;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      en_s1  <= isc_en_r;
      en_s2  <= en_s1;
      od_s1  <= isc_od_r;
      od_s2  <= od_s1;
    end
  end

  // ==========================================================
  // Flash command sequencer
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      fl_r        <= FL_READ;
      flash_req   <= '0;
      flash_abort <= 1'b1;
      ack_r       <= 1'b0;
      rd_r        <= REG_ZERO;
    end else begin
      flash_abort     <= 1'b0;
      flash_req.valid <= 1'b0;
      case (fl_r)
        FL_READ: begin
          if (new_cmd) begin
            if (refuse || cmd_r.op == OP_CLEAR || cmd_r.op == OP_NONE) begin
              ack_r <= ~ack_r;
              rd_r  <= REG_ZERO;
            end else begin
              flash_req <= '{valid: 1'b1, cmd: cmd_r};
              fl_r      <= FL_BUSY;
            end
          end
        end
        FL_BUSY: begin
          if (flash_done) begin
            fl_r  <= FL_READ;
            ack_r <= ~ack_r;
            if (flash_req.cmd.op == OP_READ) begin
              rd_r <= flash_rdata;
            end
          end
        end
        default: fl_r <= FL_READ;
      endcase
    end
  end

  // ==========================================================
  // Status and error outputs
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      err_r <= 1'b0;
    end else if (fl_r == FL_BUSY && flash_done && flash_fail && flash_req.cmd.op != OP_READ) begin
      err_r <= 1'b1;
    end else if ((new_cmd && fl_r == FL_READ && cmd_r.op == OP_CLEAR) || (rst_s2 && !en_s2)) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      isc_status_out  <= 1'b1;
      isc_status_oe_n <= 1'b1;
      isc_error_out   <= 1'b1;
      isc_error_oe_n  <= 1'b1;
    end else begin
      isc_status_out  <= ~((fl_r == FL_BUSY) | flash_sec_wr);
      isc_error_out   <= ~err_r;
      isc_status_oe_n <= ~en_s2 | (od_s2 & (fl_r != FL_BUSY) & ~flash_sec_wr);
      isc_error_oe_n  <= ~en_s2 | (od_s2 & ~err_r);
    end
  end

  // ==========================================================
  // PLD outputs, address gate and macrocells
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      pld_out      <= '0;
      pld_valid    <= 1'b0;
      pld_addr_arr <= '0;
      mc_q         <= '0;
    end else begin
      pld_valid    <= cfg_loaded;
      pld_out      <= cfg_loaded ? pld_eval : '0;
      pld_addr_arr <= pd_mode ? '0 : pld_addr;
      mc_q         <= (mc_d & ~mc_re) | mc_pr;
    end
  end

  // ==========================================================
  // Test-clock domain
  always_ff @(posedge tck or posedge por) begin
    if (por) begin
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
    end else begin
      hold_s1 <= hold_r;
      hold_s2 <= hold_s1;
      ack_s1  <= ack_r;
      ack_s2  <= ack_s1;
    end
  end

  jisp_tap u_tap (
    .tck   (tck),
    .por   (por),
    .hold  (hold_s2),
    .tms   (tms),
    .tdi   (tdi),
    .state (tap_st),
    .ir_sh (ir_sh),
    .ir_q  (ir_q)
  );

  always_ff @(posedge tck or posedge por) begin
    if (por) begin
      isc_en_r <= 1'b0;
      isc_od_r <= 1'b0;
    end else if (hold_s2) begin
      isc_en_r <= 1'b0;
      isc_od_r <= 1'b0;
    end else if (tap_st == TS_RTI) begin
      if (ir_q == IR_ENABLE || ir_q == IR_ENABLE_OD) begin
        isc_en_r <= 1'b1;
        isc_od_r <= (ir_q == IR_ENABLE_OD);
      end else if (ir_q == IR_DISABLE) begin
        isc_en_r <= 1'b0;
        isc_od_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge tck or posedge por) begin
    if (por) begin
      dr_r  <= '0;
      byp_r <= 1'b0;
      req_r <= 1'b0;
      cmd_r <= '0;
    end else if (!hold_s2) begin
      if (tap_st == TS_CAPDR) begin
        dr_r  <= (ir_q == IR_READ) ? {{(DR_W-8){1'b0}}, rd_r} : '0;
        byp_r <= 1'b0;
      end else if (tap_st == TS_SHDR) begin
        dr_r  <= {tdi, dr_r[DR_W-1:1]};
        byp_r <= tdi;
      end else if (tap_st == TS_UPDR && isc_en_r && ir_op != OP_NONE && req_r == ack_s2) begin
        cmd_r <= '{op: ir_op, sector: dr_r[DR_W-1:DR_W-4], addr: dr_r[AD_W+7:8], data: dr_r[7:0]};
        req_r <= ~req_r;
      end
    end
  end

  always_ff @(negedge tck or posedge por) begin
    if (por) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo      <= (tap_st == TS_SHIR) ? ir_sh[0] : (ir_op != OP_NONE) ? dr_r[0] : byp_r;
      tdo_oe_n <= ~(isc_en_r & (tap_st == TS_SHIR || tap_st == TS_SHDR));
    end
  end

  // ==========================================================
  // Checks
  a_gpio_follows_enable: assert property (@(posedge mclk) disable iff (por)
    1'b1 |=> pins_gpio_mode == !$past(jtag_on)) else $error("gpio mode wrong");
  a_run_en_write: assert property (@(posedge mclk) disable iff (any_rst)
    wr_hit && io_addr == OFS_RUN_EN |=> run_en_r == $past(io_wdata[0])) else $error("run enable lost");
  a_reset_abort: assert property (@(posedge mclk) disable iff (por)
    rst |-> fl_r == FL_READ && !flash_req.valid && flash_abort) else $error("abort missing");
  a_secure_refuse: assert property (@(posedge mclk) disable iff (any_rst)
    new_cmd && fl_r == FL_READ && nvm_security && cmd_r.op == OP_READ |=> !flash_req.valid)
    else $error("secured read passed");
  a_protect_block: assert property (@(posedge mclk) disable iff (any_rst)
    new_cmd && cmd_r.op == OP_ERASE && sector_protect[cmd_r.sector] |=> !flash_req.valid)
    else $error("protected erase passed");
  a_status_busy: assert property (@(posedge mclk) disable iff (por)
    fl_r == FL_BUSY |=> !isc_status_out) else $error("status high while busy");
  a_error_sticky: assert property (@(posedge mclk) disable iff (por)
    fl_r == FL_BUSY && flash_done && flash_fail && flash_req.cmd.op != OP_READ
      |=> ##1 !isc_error_out) else $error("error not shown");
  a_pm_keep: assert property (@(posedge mclk) disable iff (por)
    !wr_hit |=> $stable(power_mgmt_reg_a) && $stable(power_mgmt_reg_c)) else $error("pm reg changed");
  a_hold_dedicated: assert property (@(posedge mclk) disable iff (por)
    nvm_dedicate |=> !hold_r) else $error("dedicated port held");
  a_tdo_quiet: assert property (@(posedge tck) disable iff (por)
    !isc_en_r && $past(!isc_en_r) |-> tdo_oe_n) else $error("tdo driven early");
  c_prog_done: cover property (@(posedge mclk) disable iff (any_rst)
    fl_r == FL_BUSY && flash_done && flash_req.cmd.op == OP_PROGRAM);
  c_secure_chip: cover property (@(posedge mclk) disable iff (any_rst)
    nvm_security && flash_req.valid && flash_req.cmd.op == OP_CHIP);
  c_isc_enable: cover property (@(posedge tck) disable iff (por) $rose(isc_en_r));
endmodule : jisp_ctrl

// ==== tb/jisp_cable_model.sv ====
/*
  Serial test controller model driving the tap pins in frames.
  Assumes the device samples tms and tdi on rising tck.
*/
`timescale 1ns/1ps
module jisp_cable_model (
  // Serial pins
  output logic tck,
  output logic tms,
  output logic tdi
);
  // ==========================================================
  // Bit clocking, tck still between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic bit1(input logic m, input logic d);
    tms = m;
    tdi = d;
    #24 tck = 1'b1;
    #24 tck = 1'b0;
  endtask : bit1
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      bit1(m[i], ~tdi);
    end
  endtask : walk
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      bit1(i == n - 1, v[i]);
    end
    walk(8'h01, 2);
    tdi = ~tdi;
  endtask : shift
  // ==========================================================
  // Frames
  task automatic tlr();
    walk(8'h1f, 6);
  endtask : tlr
  task automatic ir(input logic [7:0] c);
    walk(8'h03, 4);
    shift(32'(c), 8);
  endtask : ir
  task automatic dr(input logic [27:0] v);
    walk(8'h01, 3);
    shift(32'(v), 28);
  endtask : dr
  task automatic idle(input int n);
    walk(8'h00, n);
  endtask : idle
endmodule : jisp_cable_model

// ==== tb/tb_jtag_isp_port_control.sv ====
/*
  Self-checking bench of the test-port control block.
  Assumes the cable model above and a flash responder in this bench.
*/
`timescale 1ns/1ps
module tb_jtag_isp_port_control;
  import jisp_pkg::*;
  localparam logic [7:0] MMI = 8'hff;
  logic             mclk, rst, por, tck, tms, tdi, tdo, tdo_oe_n, pins_gpio_mode, rd_d, fail_nx;
  logic             isc_status_out, isc_status_oe_n, isc_error_out, isc_error_oe_n, pd_mode;
  logic             nvm_dedicate, nvm_blank, nvm_security, cfg_loaded, test_select_product_term;
  logic             io_sel, io_wr, io_rd, flash_abort, flash_done, flash_fail, flash_sec_wr, pld_valid;
  logic [NSECT-1:0] sector_protect;
  logic [7:0]       io_addr, io_wdata, io_rdata, flash_rdata, r, mme;
  logic [7:0]       memory_map_reg, power_mgmt_reg_a, power_mgmt_reg_c;
  logic [AD_W-1:0]  pld_addr, pld_addr_arr;
  logic [PLD_W-1:0] pld_eval, pld_out;
  logic [MC_W-1:0]  mc_d, mc_re, mc_pr, mc_q;
  jisp_freq_t       flash_req;
  logic [7:0]       rq[$];
  jisp_cmd_t        fq[$];
  int               mismatches, comparisons;
  // ==========================================================
  // Design and partner
  jisp_ctrl #(.MM_INIT(MMI)) jisp_ctrl_inst (
    .mclk, .rst, .por, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .isc_status_out, .isc_status_oe_n,
    .isc_error_out, .isc_error_oe_n, .pins_gpio_mode, .nvm_dedicate, .nvm_blank, .nvm_security,
    .sector_protect, .cfg_loaded, .test_select_product_term, .io_sel, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .flash_req, .flash_abort, .flash_done, .flash_fail, .flash_rdata,
    .flash_sec_wr, .pd_mode, .pld_addr, .pld_addr_arr, .pld_eval, .pld_out, .pld_valid, .mc_d,
    .mc_re, .mc_pr, .mc_q, .memory_map_reg, .power_mgmt_reg_a, .power_mgmt_reg_c);
  jisp_cable_model jisp_cable_model_inst (.tck, .tms, .tdi);
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {io_sel, io_wr, io_addr, io_wdata} = {2'b11, a, d};
    cyc(1);
    {io_sel, io_wr} = 2'b00;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    {io_sel, io_rd, io_addr} = {2'b11, a};
    cyc(1);
    {io_sel, io_rd} = 2'b00;
    cyc(1);
  endtask : rd
  task automatic cmd(input logic [7:0] c, input jisp_op_t o, input logic [3:0] s, input bit go, input bit f);
    logic [15:0] a;
    logic [7:0]  d;
    a = 16'($urandom());
    d = 8'($urandom());
    if (go) fq.push_back({o, s, a, d});
    fail_nx = f;
    jisp_cable_model_inst.ir(c);
    jisp_cable_model_inst.dr({s, a, d});
    cyc(8);
    for (int i = 0; i < 300 && isc_status_out !== 1'b1; i++) cyc(1);
    jisp_cable_model_inst.idle(12);
    cyc(1);
  endtask : cmd
  // ==========================================================
  // Result watchers and flash responder
  always @(posedge mclk) begin
    if (rd_d) chk("io_rdata", 32'(io_rdata), 32'(rq.pop_front()));
    rd_d <= io_sel & io_rd;
  end
  initial forever begin
    @(posedge mclk);
    if (flash_req.valid === 1'b1) begin
      if (flash_req.cmd.op !== OP_CLEAR)
        chk("flash_req", 32'(flash_req.cmd), fq.size() ? 32'(fq.pop_front()) : 32'hffffffff);
      cyc(3);
      chk("status busy", 32'(isc_status_out), 32'h0);
      {flash_done, flash_fail, flash_rdata} = {1'b1, fail_nx, 8'($urandom())};
      cyc(1);
      {flash_done, flash_fail} = 2'b00;
    end
  end
  initial begin
    #2_000_000;
    mismatches++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, por, nvm_dedicate, nvm_blank, nvm_security, cfg_loaded, test_select_product_term} = 7'h60;
    {pd_mode, io_sel, io_wr, io_rd, flash_done, flash_fail, flash_sec_wr, rd_d, fail_nx} = '0;
    {io_addr, io_wdata, flash_rdata, sector_protect, mc_re, mc_pr} = '0;
    mismatches = 0;
    comparisons = 0;
    r = 8'($urandom(32'h96fea166));
    {pld_addr, pld_eval, mc_d} = {16'($urandom()), 8'($urandom()), 16'($urandom())};
    mme = MMI & ~(8'h01 << MM_SRCOD_BIT) & ~(8'h01 << MM_PERIPH_BIT);
    fork
      jisp_cable_model_inst.idle(3);
    join_none
    cyc(8);
    chk("mc_q por", 32'(mc_q), 32'h0);
    chk("pld_out por", 32'(pld_out), 32'h0);
    {rst, por} = 2'b00;
    cyc(4);
    chk("pmr_a", 32'(power_mgmt_reg_a), 32'h0);
    chk("pmr_c", 32'(power_mgmt_reg_c), 32'h0);
    chk("memmap", 32'(memory_map_reg), 32'(mme));
    chk("gpio", 32'(pins_gpio_mode), 32'h1);
    wr(OFS_PMR_A, r);
    rd(OFS_RUN_EN, REG_ZERO);
    wr(OFS_RUN_EN, 8'hff);
    rd(OFS_RUN_EN, 8'h01);
    chk("gpio run", 32'(pins_gpio_mode), 32'h0);
    rd(8'h55, REG_ZERO);
    rst = 1'b1;
    cyc(1);
    chk("abort", 32'(flash_abort), 32'h1);
    rst = 1'b0;
    cyc(2);
    chk("gpio rst", 32'(pins_gpio_mode), 32'h1);
    chk("pmr_a keep", 32'(power_mgmt_reg_a), 32'(r));
    chk("memmap rst", 32'(memory_map_reg), 32'(mme));
    rd(OFS_RUN_EN, REG_ZERO);
    wr(OFS_RUN_EN, 8'h01);
    wr(OFS_RUN_EN, 8'h00);
    chk("gpio off", 32'(pins_gpio_mode), 32'h1);
    test_select_product_term = 1'b1;
    cyc(2);
    chk("gpio term", 32'(pins_gpio_mode), 32'h0);
    {test_select_product_term, cfg_loaded} = 2'b01;
    cyc(2);
    chk("pld_out", 32'(pld_out), 32'(pld_eval));
    chk("pld_valid", 32'(pld_valid), 32'h1);
    {pd_mode, mc_pr} = {1'b1, 16'hffff};
    cyc(2);
    chk("pld_addr_arr", 32'(pld_addr_arr), 32'h0);
    chk("mc_q preset", 32'(mc_q), 32'hffff);
    nvm_dedicate = 1'b1;
    cyc(2);
    chk("gpio nvm", 32'(pins_gpio_mode), 32'h0);
    jisp_cable_model_inst.tlr();
    jisp_cable_model_inst.ir(IR_ENABLE);
    jisp_cable_model_inst.idle(4);
    cyc(2);
    chk("stat_oe", 32'(isc_status_oe_n), 32'h0);
    chk("err_oe", 32'(isc_error_oe_n), 32'h0);
    chk("tdo_oe idle", 32'(tdo_oe_n), 32'h1);
    chk("status read", 32'(isc_status_out), 32'h1);
    flash_sec_wr = 1'b1;
    cyc(2);
    chk("status sec", 32'(isc_status_out), 32'h0);
    flash_sec_wr = 1'b0;
    cyc(2);
    cmd(IR_PROGRAM, OP_PROGRAM, 4'h2, 1'b1, 1'b1);
    chk("error set", 32'(isc_error_out), 32'h0);
    cmd(IR_CLEAR, OP_CLEAR, 4'h0, 1'b0, 1'b0);
    chk("error clr", 32'(isc_error_out), 32'h1);
    nvm_security = 1'b1;
    cmd(IR_PROGRAM, OP_PROGRAM, 4'h1, 1'b0, 1'b0);
    cmd(IR_READ, OP_READ, 4'h0, 1'b0, 1'b0);
    cmd(IR_CHIP, OP_CHIP, 4'h0, 1'b1, 1'b0);
    nvm_security = 1'b0;
    sector_protect = (NSECT'($urandom()) & ~12'h010) | 12'h020;
    cmd(IR_ERASE, OP_ERASE, 4'h5, 1'b0, 1'b0);
    cmd(IR_ERASE, OP_ERASE, 4'h4, 1'b1, 1'b0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    chk("gpio dedicated", 32'(pins_gpio_mode), 32'h0);
    chk("requests left", 32'(fq.size()), 32'h0);
    give_verdict();
  end
endmodule : tb_jtag_isp_port_control
